/* File: logic/error_status_flags.sv */
// Error status register: sticky flags, config access, system-error requests
// Function
// - Flag rising with enables raises system-error message
// - Flags other than the thermal bit set regardless of reporting enables
// - Writing one clears flag; zero keeps it
// - Writes ignored under security modes or lock
// - Bit 12 records graphics software SMI event
// - Thermal bit set only when message sent
// - Later thermal trips may be dropped
// - No thermal message while thermal flag set
// - Bit 9 records locked access outside DRAM
// - Bit 8 set at 1024 queued refreshes
// - Bit 7 records DRAM throttling until cleared
// - Global enable also gates system-error messages
// - Report enables share their flag bit positions
module error_status_flags
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_pwrgood_rst_n,

    input  wire logic [7:0]  i_cfg_addr,
    input  wire logic        i_cfg_wr,
    input  wire logic        i_cfg_rd,
    input  wire logic [1:0]  i_cfg_be,
    input  wire logic [15:0] i_cfg_wdata,
    output logic      [15:0] o_cfg_rdata,
    output logic             o_cfg_rvalid,

    input  wire logic [15:0] i_error_command_enables,
    input  wire logic        i_serr_global_enable,
    input  wire logic        i_thermal_smi_enable,
    input  wire logic        i_thermal_sci_enable,

    input  wire logic        i_trusted_mode,
    input  wire logic        i_mgmt_fw_mode,
    input  wire logic        i_memory_range_lock_bit,

    input  wire logic        i_gfx_sw_smi_event,
    input  wire logic        i_thermal_trip,
    input  wire logic        i_lock_nondram_event,
    input  wire logic        i_refresh_enqueue,
    input  wire logic        i_refresh_dequeue,
    input  wire logic        i_dram_throttle,

    output logic             o_serr_req,
    input  wire logic        i_serr_ack,
    output logic             o_thermal_smi,
    output logic             o_thermal_sci
);

    typedef struct packed
    {
        logic        serr_req;
        logic [15:0] rdata;
        logic        rvalid;
        logic        therm_smi;
        logic        therm_sci;
    } ctrl_state_t;

    ctrl_state_t state_reg;
    ctrl_state_t state_next;

    flag_bank_if fb ();

    logic        refresh_timeout;
    logic        cfg_hit;
    logic        wr_locked;
    logic [15:0] byte_mask;
    logic        thermal_serr_route;
    logic        thermal_send;
    logic        serr_fire;

    refresh_backlog_counter u_refresh
    (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_enqueue (i_refresh_enqueue),
        .i_dequeue (i_refresh_dequeue),
        .o_timeout (refresh_timeout)
    );

    sticky_flag_bank u_bank
    (
        .i_ref_clk       (i_ref_clk),
        .i_pwrgood_rst_n (i_pwrgood_rst_n),
        .fb              (fb)
    );

    // Only the upper seven address bits select the 16-bit register
    assign cfg_hit   = (i_cfg_addr[7:1] == error_status_pkg::ERR_STATUS_OFFSET[7:1]);
    assign wr_locked = i_trusted_mode | i_mgmt_fw_mode | i_memory_range_lock_bit;
    assign byte_mask = {{8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};

    always_comb
    begin
        fb.clr_vec = 16'h0000;
        if (i_cfg_wr && cfg_hit && !wr_locked)
            fb.clr_vec = i_cfg_wdata & byte_mask & error_status_pkg::FLAG_MASK;
    end

    // Trip point routing conflicts are software's problem; any route sends
    assign thermal_serr_route = i_error_command_enables[error_status_pkg::BIT_THERMAL]
                                & i_serr_global_enable;
    assign thermal_send = i_thermal_trip
                          && !fb.flags[error_status_pkg::BIT_THERMAL]
                          && (i_thermal_smi_enable || i_thermal_sci_enable
                              || thermal_serr_route);

    always_comb
    begin
        fb.set_vec = 16'h0000;
        fb.set_vec[error_status_pkg::BIT_GFX_SMI]  = i_gfx_sw_smi_event;
        fb.set_vec[error_status_pkg::BIT_THERMAL]  = thermal_send;
        fb.set_vec[error_status_pkg::BIT_LOCK]     = i_lock_nondram_event;
        fb.set_vec[error_status_pkg::BIT_REFRESH]  = refresh_timeout;
        fb.set_vec[error_status_pkg::BIT_THROTTLE] = i_dram_throttle;
    end

    // Bit 12 has no report enable, so it never raises a system-error request
    assign serr_fire = (|(fb.rise & i_error_command_enables
                          & error_status_pkg::SERR_MASK))
                       && i_serr_global_enable;

    always_comb
    begin
        state_next = state_reg;
        // A new rise outranks the acknowledge so no message is lost
        if (serr_fire)
            state_next.serr_req = 1'b1;
        else if (i_serr_ack)
            state_next.serr_req = 1'b0;
        state_next.therm_smi = thermal_send && i_thermal_smi_enable;
        state_next.therm_sci = thermal_send && i_thermal_sci_enable;
        state_next.rvalid    = i_cfg_rd;
        if (i_cfg_rd)
        begin
            if (cfg_hit)
                state_next.rdata = fb.flags & error_status_pkg::FLAG_MASK;
            else
                state_next.rdata = 16'h0000;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state_reg <= '{serr_req: 1'b0, rdata: 16'h0000, rvalid: 1'b0,
                           therm_smi: 1'b0, therm_sci: 1'b0};
        else
            state_reg <= state_next;
    end

    assign o_serr_req    = state_reg.serr_req;
    assign o_cfg_rdata   = state_reg.rdata;
    assign o_cfg_rvalid  = state_reg.rvalid;
    assign o_thermal_smi = state_reg.therm_smi;
    assign o_thermal_sci = state_reg.therm_sci;

    default clocking cb @(posedge i_ref_clk);
    endclocking

    default disable iff (!i_rst_n || !i_pwrgood_rst_n);

    sequence s_unlocked_write(int b);
        i_cfg_wr && cfg_hit && !wr_locked && i_cfg_wdata[b] && byte_mask[b];
    endsequence

    sequence s_lock_rise;
        i_lock_nondram_event && !fb.flags[error_status_pkg::BIT_LOCK]
        && i_error_command_enables[error_status_pkg::BIT_LOCK];
    endsequence

    a_serr_on_rise : assert property (
        s_lock_rise ##0 i_serr_global_enable |=> o_serr_req)
        else $error("no system-error request after enabled rise");

    a_serr_global_gate : assert property (
        !o_serr_req && !i_serr_global_enable |=> !o_serr_req)
        else $error("system-error request without global enable");

    a_flag_unconditional : assert property (
        i_lock_nondram_event && !i_serr_global_enable |=> fb.flags[error_status_pkg::BIT_LOCK])
        else $error("lock flag not set while reporting disabled");

    a_w1c_clears : assert property (
        s_unlocked_write(error_status_pkg::BIT_THROTTLE) ##0 !i_dram_throttle
        |=> !fb.flags[error_status_pkg::BIT_THROTTLE])
        else $error("throttle flag not cleared by write of one");

    a_locked_write : assert property (
        i_cfg_wr && wr_locked && fb.set_vec == 16'h0000 |=> $stable(fb.flags))
        else $error("flags changed by a locked write");

    a_gfx_smi_flag : assert property (
        i_gfx_sw_smi_event |=> fb.flags[error_status_pkg::BIT_GFX_SMI])
        else $error("graphics software event not recorded");

    a_thermal_unsent : assert property (
        i_thermal_trip && !i_thermal_smi_enable && !i_thermal_sci_enable
        && !thermal_serr_route && !fb.flags[error_status_pkg::BIT_THERMAL]
        |=> !fb.flags[error_status_pkg::BIT_THERMAL])
        else $error("thermal flag set with no message sent");

    a_thermal_quiet : assert property (
        i_thermal_trip && fb.flags[error_status_pkg::BIT_THERMAL]
        |=> !o_thermal_smi && !o_thermal_sci)
        else $error("thermal message sent while thermal flag set");

    a_refresh_flag : assert property (
        refresh_timeout |=> fb.flags[error_status_pkg::BIT_REFRESH])
        else $error("refresh timeout not recorded");

    a_reserved_zero : assert property (
        o_cfg_rvalid |-> (o_cfg_rdata & ~error_status_pkg::FLAG_MASK) == 16'h0000)
        else $error("reserved bits read nonzero");

    sequence s_serr_pending;
        o_serr_req && !i_serr_ack;
    endsequence

    sequence s_serr_accepted;
        o_serr_req && i_serr_ack && (fb.rise == 16'h0000);
    endsequence

    sequence s_thermal_open;
        i_thermal_trip && !fb.flags[error_status_pkg::BIT_THERMAL];
    endsequence

    sequence s_hit_read;
        i_cfg_rd && cfg_hit;
    endsequence

    // Dropping a request before the hub accepts it would lose the message
    a_serr_held : assert property (
        s_serr_pending |=> o_serr_req)
        else $error("system-error request dropped before acknowledge");

    a_serr_release : assert property (
        s_serr_accepted |=> !o_serr_req)
        else $error("system-error request held after acknowledge");

    // Bit 12 lies outside the reportable set, so its rise must stay silent
    a_serr_needs_rise : assert property (
        !o_serr_req && (fb.rise & error_status_pkg::SERR_MASK) == 16'h0000 |=> !o_serr_req)
        else $error("system-error request without a reportable rise");

    a_read_valid : assert property (
        i_cfg_rd |=> o_cfg_rvalid)
        else $error("read answered without valid");

    a_read_single : assert property (
        !i_cfg_rd |=> !o_cfg_rvalid)
        else $error("read valid without a read");

    a_read_flags : assert property (
        s_hit_read |=> o_cfg_rdata == $past(fb.flags))
        else $error("read data differs from flags");

    a_read_unmapped : assert property (
        i_cfg_rd && !cfg_hit |=> o_cfg_rdata == 16'h0000)
        else $error("unmapped read returned nonzero");

    a_rdata_held : assert property (
        !i_cfg_rd |=> $stable(o_cfg_rdata))
        else $error("read data changed without a read");

    a_zero_keeps : assert property (
        i_cfg_wr && !i_cfg_wdata[error_status_pkg::BIT_LOCK]
        && fb.flags[error_status_pkg::BIT_LOCK] |=> fb.flags[error_status_pkg::BIT_LOCK])
        else $error("write of zero cleared a flag");

    a_lane_keeps : assert property (
        i_cfg_wr && !i_cfg_be[1] && fb.flags[error_status_pkg::BIT_GFX_SMI]
        |=> fb.flags[error_status_pkg::BIT_GFX_SMI])
        else $error("disabled byte lane cleared a flag");

    a_locked_keeps : assert property (
        wr_locked && fb.flags[error_status_pkg::BIT_LOCK] |=> fb.flags[error_status_pkg::BIT_LOCK])
        else $error("flag cleared while writes are locked");

    a_thermal_smi : assert property (
        s_thermal_open ##0 i_thermal_smi_enable
        |=> o_thermal_smi && fb.flags[error_status_pkg::BIT_THERMAL])
        else $error("routed thermal trip gave no interrupt pulse");

    a_thermal_sci : assert property (
        s_thermal_open ##0 i_thermal_sci_enable
        |=> o_thermal_sci && fb.flags[error_status_pkg::BIT_THERMAL])
        else $error("routed thermal trip gave no control pulse");

    a_thermal_serr : assert property (
        s_thermal_open ##0 i_error_command_enables[error_status_pkg::BIT_THERMAL]
        ##0 i_serr_global_enable |=> o_serr_req && fb.flags[error_status_pkg::BIT_THERMAL])
        else $error("routed thermal trip gave no system-error request");

    a_smi_pulse : assert property (
        o_thermal_smi |=> !o_thermal_smi)
        else $error("thermal interrupt pulse longer than one cycle");

    a_sci_pulse : assert property (
        o_thermal_sci |=> !o_thermal_sci)
        else $error("thermal control pulse longer than one cycle");

    a_throttle_set : assert property (
        i_dram_throttle |=> fb.flags[error_status_pkg::BIT_THROTTLE])
        else $error("throttle condition not recorded");

    a_refresh_quiet : assert property (
        !refresh_timeout && !fb.flags[error_status_pkg::BIT_REFRESH]
        |=> !fb.flags[error_status_pkg::BIT_REFRESH])
        else $error("refresh flag set without timeout");

    a_lock_quiet : assert property (
        !i_lock_nondram_event && !fb.flags[error_status_pkg::BIT_LOCK]
        |=> !fb.flags[error_status_pkg::BIT_LOCK])
        else $error("lock flag set without locked access");

endmodule

/* File: logic/error_status_pkg.sv */
// Constants shared by the error status register bank
package error_status_pkg;

    localparam logic [7:0]  ERR_STATUS_OFFSET = 8'hc8;
    localparam logic [15:0] ERR_STATUS_RESET  = 16'h0000;

    localparam int BIT_GFX_SMI  = 12;
    localparam int BIT_THERMAL  = 11;
    localparam int BIT_LOCK     = 9;
    localparam int BIT_REFRESH  = 8;
    localparam int BIT_THROTTLE = 7;

    // Implemented flag bits; all others read as zero
    localparam logic [15:0] FLAG_MASK = 16'h1b80;
    // Flags that have a matching report enable in the error command register
    localparam logic [15:0] SERR_MASK = 16'h0b80;

    localparam logic [10:0] REFRESH_LIMIT = 11'h400;
    localparam logic [10:0] REFRESH_RESET = 11'h000;

endpackage

/* File: logic/flag_bank_if.sv */
// Carrier between the control logic and the sticky flag bank
interface flag_bank_if;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic [15:0] flags;
    logic [15:0] rise;

    modport bank (input set_vec, input clr_vec, output flags, output rise);
    modport ctrl (output set_vec, output clr_vec, input flags, input rise);
endinterface

/* File: logic/sticky_flag_bank.sv */
// Sticky write-one-to-clear flag storage, cleared only by power-good reset
module sticky_flag_bank
(
    input  wire logic   i_ref_clk,
    input  wire logic   i_pwrgood_rst_n,
    flag_bank_if.bank   fb
);

    typedef struct packed
    {
        logic [15:0] flags;
    } bank_state_t;

    bank_state_t state_reg;
    bank_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        // Set wins over a clear landing in the same cycle
        state_next.flags = ((state_reg.flags & ~fb.clr_vec) | fb.set_vec)
                           & error_status_pkg::FLAG_MASK;
    end

    always_ff @(posedge i_ref_clk or negedge i_pwrgood_rst_n)
    begin
        if (!i_pwrgood_rst_n)
            state_reg <= '{flags: error_status_pkg::ERR_STATUS_RESET};
        else
            state_reg <= state_next;
    end

    assign fb.flags = state_reg.flags;
    assign fb.rise  = fb.set_vec & ~state_reg.flags & error_status_pkg::FLAG_MASK;

    a_set_beats_clear : assert property (
        @(posedge i_ref_clk) disable iff (!i_pwrgood_rst_n)
        fb.set_vec[error_status_pkg::BIT_LOCK] |=> fb.flags[error_status_pkg::BIT_LOCK])
        else $error("lock flag lost against clear");

endmodule

/* File: logic/refresh_backlog_counter.sv */
// Counts queued core refreshes and pulses once when the backlog reaches its limit
module refresh_backlog_counter
(
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_enqueue,
    input  wire logic i_dequeue,
    output logic      o_timeout
);

    typedef struct packed
    {
        logic [10:0] count;
        logic        timeout;
    } cnt_state_t;

    cnt_state_t state_reg;
    cnt_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        if (i_enqueue && !i_dequeue && state_reg.count != error_status_pkg::REFRESH_LIMIT)
            state_next.count = state_reg.count + 11'h001;
        else if (i_dequeue && !i_enqueue && state_reg.count != 11'h000)
            state_next.count = state_reg.count - 11'h001;
        state_next.timeout = (state_next.count == error_status_pkg::REFRESH_LIMIT)
                             && (state_reg.count != error_status_pkg::REFRESH_LIMIT);
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state_reg <= '{count: error_status_pkg::REFRESH_RESET, timeout: 1'b0};
        else
            state_reg <= state_next;
    end

    assign o_timeout = state_reg.timeout;

    a_backlog_capped : assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        state_reg.count <= error_status_pkg::REFRESH_LIMIT)
        else $error("refresh backlog above limit");

endmodule

/* File: verif/serr_hub_model.sv */
// Downstream hub model that accepts system-error requests promptly or slowly
module serr_hub_model
(
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_serr_req,
    input  wire logic i_slow,
    output logic      o_serr_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_cnt = 0;
    initial o_serr_ack = 1'b0;
    // Ack is a one-cycle pulse raised only while a request stands
    always @(posedge i_ref_clk)
    begin
        #1;
        if (!i_rst_n || i_serr_req !== 1'b1 || o_serr_ack)
        begin
            wait_cnt = 0;
            o_serr_ack <= 1'b0;
        end
        else if (wait_cnt >= (i_slow ? 6 : 0))
        begin
            wait_cnt = 0;
            o_serr_ack <= 1'b1;
        end
        else
            wait_cnt++;
    end
endmodule

/* File: verif/error_status_flags_bench.sv */
// Self-checking bench for the error status register bank
module error_status_flags_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, pg_n, wr, rd, glob, smi_en, sci_en, slow;
    logic        rvalid, req, ack, tsmi, tsci, req_d;
    logic [2:0]  lk;
    logic [5:0]  ev;
    logic [7:0]  addr;
    logic [1:0]  be;
    logic [15:0] wdata, rdata, en, sh;
    logic [31:0] seed = 32'hb2d90ff7;
    int          n_mismatch = 0, comparisons = 0, n_req = 0, n_smi = 0, n_sci = 0, cycles = 0;
    error_status_flags DUT
    (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_pwrgood_rst_n(pg_n),
        .i_cfg_addr(addr), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_be(be),
        .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
        .i_error_command_enables(en), .i_serr_global_enable(glob),
        .i_thermal_smi_enable(smi_en), .i_thermal_sci_enable(sci_en),
        .i_trusted_mode(lk[0]), .i_mgmt_fw_mode(lk[1]), .i_memory_range_lock_bit(lk[2]),
        .i_gfx_sw_smi_event(ev[0]), .i_thermal_trip(ev[1]), .i_lock_nondram_event(ev[2]),
        .i_refresh_enqueue(ev[3]), .i_dram_throttle(ev[4]), .i_refresh_dequeue(ev[5]),
        .o_serr_req(req), .i_serr_ack(ack), .o_thermal_smi(tsmi), .o_thermal_sci(tsci)
    );
    serr_hub_model hub
    (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_serr_req(req), .i_slow(slow), .o_serr_ack(ack)
    );
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Counting rises and pulses catches both missing and extra messages;
    // the falling edge keeps the count clear of the launching edge
    always @(negedge clk)
    begin
        cycles++;
        n_req += (req === 1'b1 && req_d !== 1'b1);
        n_smi += (tsmi === 1'b1);
        n_sci += (tsci === 1'b1);
        req_d = req;
        if (cycles == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [15:0] after_clear(logic [15:0] f, d, logic [1:0] b);
        return f & ~(d & {{8{b[1]}}, {8{b[0]}}});
    endfunction
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, exp, input string m);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cfg_wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
        {addr, be, wdata, wr} = {a, b, d, 1'b1};
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        {addr, rd} = {a, 1'b1};
        tick(1);
        rd = 1'b0;
        check({15'h0, rvalid}, 16'h1, "read valid");
        check(rdata, exp, "read data");
        tick(1);
    endtask
    // Low at both ends so back-to-back events never reassign in one step
    task automatic pulse(input int k);
        ev = 6'h01 << k;
        tick(1);
        ev = 6'h00;
        tick(1);
    endtask
    task automatic clr_all();
        cfg_wr(8'hc8, 2'h3, 16'hffff);
    endtask
    initial
    begin
        {wr, rd, glob, smi_en, sci_en, slow, rst_n, pg_n} = '0;
        {lk, ev, addr, be, wdata, en, sh} = '0;
        repeat (6) @(posedge clk);
        #1;
        {rst_n, pg_n} = 2'b11;
        tick(1);
        rd_chk(8'hc8, 16'h0000);
        rd_chk(8'hca, 16'h0000);
        pulse(0);
        pulse(2);
        pulse(4);
        sh = 16'h1280;
        rd_chk(8'hc9, sh);
        for (int i = 0; i < 3; i++)
        begin
            lk = 3'h1 << i;
            clr_all();
        end
        lk = 3'h0;
        rd_chk(8'hc8, sh);
        for (int i = 0; i < 12; i++)
        begin
            seed = xs(seed);
            ev = 6'h15;
            tick(1);
            ev = 6'h00;
            sh = 16'h1280;
            cfg_wr(seed[0] ? 8'hc8 : 8'hc9, seed[9:8], seed[31:16]);
            sh = after_clear(sh, seed[31:16], seed[9:8]);
            rd_chk(8'hc8, sh);
        end
        clr_all();
        // Throttle still active while its clear lands: the flag must survive
        ev = 6'h10;
        cfg_wr(8'hc8, 2'h1, 16'h0080);
        ev = 6'h00;
        rd_chk(8'hc8, 16'h0080);
        check(16'(n_req), 16'h0, "request while disabled");
        {en, glob, slow} = {16'h0b80, 2'b11};
        pulse(2);
        tick(3);
        check({15'h0, req}, 16'h1, "request held");
        tick(8);
        check({15'h0, req}, 16'h0, "request after ack");
        pulse(2);
        clr_all();
        glob = 1'b0;
        pulse(2);
        clr_all();
        {glob, en, slow} = {1'b1, 16'h0a00, 1'b0};
        pulse(4);
        clr_all();
        en = 16'h0080;
        pulse(4);
        tick(10);
        check(16'(n_req), 16'h2, "request count");
        clr_all();
        {glob, en} = '0;
        pulse(1);
        rd_chk(8'hc8, 16'h0000);
        smi_en = 1'b1;
        pulse(1);
        pulse(1);
        rd_chk(8'hc8, 16'h0800);
        check(16'(n_smi), 16'h1, "smi pulses");
        clr_all();
        {smi_en, sci_en} = 2'b01;
        pulse(1);
        check(16'(n_sci), 16'h1, "sci pulses");
        clr_all();
        {sci_en, glob, en} = {2'b01, 16'h0800};
        pulse(1);
        tick(8);
        check(16'(n_req), 16'h3, "thermal request");
        clr_all();
        en = 16'h0100;
        ev = 6'h08;
        tick(1023);
        ev = 6'h00;
        tick(3);
        rd_chk(8'hc8, 16'h0000);
        pulse(3);
        tick(1);
        rd_chk(8'hc8, 16'h0100);
        tick(6);
        check(16'(n_req), 16'h4, "refresh request");
        clr_all();
        pulse(3);
        tick(1);
        rd_chk(8'hc8, 16'h0000);
        pulse(5);
        pulse(3);
        tick(1);
        rd_chk(8'hc8, 16'h0100);
        // Warm reset with a slow request in flight: request drops, flags stay
        {slow, en} = {1'b1, 16'h0180};
        pulse(4);
        check({15'h0, req}, 16'h1, "request pending");
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(1);
        check({15'h0, req}, 16'h0, "request after reset");
        rd_chk(8'hc8, 16'h0180);
        // A backlog left at its limit would time out again on this pair
        clr_all();
        pulse(5);
        pulse(3);
        tick(1);
        rd_chk(8'hc8, 16'h0000);
        check(16'(n_req), 16'h6, "request total");
        final_report();
    end
endmodule
